// *** rtl/pcn_pkg.sv ***
// Package for the port change-notification block.
// Assumes a 32-bit Avalon-MM register bus with word addressing in bytes.
package pcn_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_PORT = 8'h08;
  localparam logic [7:0] ADDR_EDGE = 8'h0c;
  localparam logic [7:0] ADDR_MISM = 8'h10;
  localparam logic [7:0] ADDR_ISTS = 8'h14;
  localparam logic [7:0] ADDR_IMSK = 8'h18;

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int CTRL_ON_BIT = 15;
  localparam int CTRL_STYLE_BIT = 11;
  localparam logic [15:0] CTRL_IMPL_MASK = 16'h8800;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] MASK_RESET = 16'h0000;

  // Interrupt status bits
  localparam int IRQ_EDGE_BIT = 0;
  localparam int IRQ_MISM_BIT = 1;
  localparam int IRQ_W = 2;

  typedef enum logic [0:0]
  {
    PCN_IDLE = 1'b0,
    PCN_ACK = 1'b1
  } pcn_bus_state_t;

  typedef struct packed
  {
    logic on;
    logic edge_style;
  } pcn_ctrl_t;

endpackage

// *** rtl/pcn_sync.sv ***
// Three-stage pin synchroniser with agreement filter.
// Assumes asynchronous pins; output changes once stages two and three agree.
`timescale 1ns/1ps
module pcn_sync
#(
  parameter int WIDTH = 16
)
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);
  logic [WIDTH-1:0] s1_r, s2_r, s3_r, out_r;
  logic [WIDTH-1:0] out_nxt;

  always_comb
  begin
    out_nxt = out_r;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (s2_r[i] == s3_r[i])
      begin
        out_nxt[i] = s3_r[i];
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      out_r <= '0;
    end
    else
    begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign pin_out = out_r;
endmodule // pcn_sync

// *** rtl/pcn_top.sv ***
// Change-notification logic for one 16-pin port, Avalon-MM slave.
// Assumes pins are asynchronous; one clock, synchronous active-high reset.
// Operation
// - Style one: record edge transitions of enabled pins in edge flag bits.
// - Style zero: record enabled pins differing from last port read in mismatch bits.
// - Each pin raises change events only while its enable-mask bit is one.
// - Unimplemented control bits read zero; writes to them are ignored.
//
// Chosen here: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
module pcn_top
#(
  parameter int PINS = 16
)
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [PINS-1:0] port_pins,
  output logic irq
);

  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  logic [PINS-1:0] pins_s;

  pcn_sync #(.WIDTH(PINS)) u_sync
  (
    .clock(clock),
    .reset(reset),
    .pin_in(port_pins),
    .pin_out(pins_s)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [15:0] ctrl_r, ctrl_nxt;
  logic [PINS-1:0] mask_r, mask_nxt;
  logic [PINS-1:0] prev_r, prev_nxt;
  logic [PINS-1:0] last_read_r, last_read_nxt;
  logic [PINS-1:0] edge_r, edge_nxt;
  logic [PINS-1:0] mism_r, mism_nxt;
  logic [pcn_pkg::IRQ_W-1:0] ists_r, ists_nxt;
  logic [pcn_pkg::IRQ_W-1:0] imsk_r, imsk_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic irq_r, irq_nxt;
  pcn_pkg::pcn_bus_state_t st_r, st_nxt;
  pcn_pkg::pcn_ctrl_t cfg;
  logic [PINS-1:0] edge_hit, mism_hit;
  logic [31:0] rd_mux;
  logic wr_go, rd_go;
  logic [15:0] wlo;
  logic [15:0] wbe;

  assign cfg.on = ctrl_r[pcn_pkg::CTRL_ON_BIT];
  assign cfg.edge_style = ctrl_r[pcn_pkg::CTRL_STYLE_BIT];

  // Low halfword with byte enables applied
  assign wlo = {avs_byteenable[1] ? avs_writedata[15:8] : 8'h00,
                avs_byteenable[0] ? avs_writedata[7:0] : 8'h00};

  // Lane mask; a disabled lane keeps the old bits of a plain register
  assign wbe = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // One-wait-state handshake: request taken in IDLE, answered in ACK
  assign wr_go = (st_r == pcn_pkg::PCN_IDLE) && avs_write;
  assign rd_go = (st_r == pcn_pkg::PCN_IDLE) && avs_read;

  always_comb
  begin
    case (st_r)
      pcn_pkg::PCN_IDLE: st_nxt = (avs_read || avs_write) ? pcn_pkg::PCN_ACK : pcn_pkg::PCN_IDLE;
      pcn_pkg::PCN_ACK: st_nxt = pcn_pkg::PCN_IDLE;
      default: st_nxt = pcn_pkg::PCN_IDLE;
    endcase
  end

  // ----------------------------------------
  // Detection
  // ----------------------------------------
  always_comb
  begin
    edge_hit = '0;
    mism_hit = '0;
    if (cfg.on)
    begin
      if (cfg.edge_style)
      begin
        edge_hit = (pins_s ^ prev_r) & mask_r;
      end
      else
      begin
        mism_hit = (pins_s ^ last_read_r) & mask_r;
      end
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  function automatic logic sel(input logic [7:0] a);
    sel = (avs_address == a);
  endfunction

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    mask_nxt = mask_r;
    imsk_nxt = imsk_r;
    prev_nxt = pins_s;
    last_read_nxt = last_read_r;
    edge_nxt = edge_r;
    mism_nxt = mism_r;
    ists_nxt = ists_r;
    if (wr_go)
    begin
      if (sel(pcn_pkg::ADDR_CTRL))
      begin
        ctrl_nxt = ((ctrl_r & ~wbe) | wlo) & pcn_pkg::CTRL_IMPL_MASK;
      end
      if (sel(pcn_pkg::ADDR_MASK))
      begin
        mask_nxt = (mask_r & ~wbe[PINS-1:0]) | wlo[PINS-1:0];
      end
      if (sel(pcn_pkg::ADDR_IMSK))
      begin
        imsk_nxt = (imsk_r & ~wbe[pcn_pkg::IRQ_W-1:0]) | wlo[pcn_pkg::IRQ_W-1:0];
      end
      // Write-one-to-clear; hardware set below wins
      if (sel(pcn_pkg::ADDR_EDGE))
      begin
        edge_nxt = edge_r & ~wlo[PINS-1:0];
      end
      if (sel(pcn_pkg::ADDR_ISTS))
      begin
        ists_nxt = ists_r & ~wlo[pcn_pkg::IRQ_W-1:0];
      end
    end
    // Port read re-arms the mismatch reference and clears the mismatch bits; a hit against the old reference set below wins
    if (rd_go && sel(pcn_pkg::ADDR_PORT))
    begin
      last_read_nxt = pins_s;
      mism_nxt = '0;
    end
    edge_nxt = edge_nxt | edge_hit;
    mism_nxt = mism_nxt | mism_hit;
    if (|edge_hit)
    begin
      ists_nxt[pcn_pkg::IRQ_EDGE_BIT] = 1'b1;
    end
    if (|mism_hit)
    begin
      ists_nxt[pcn_pkg::IRQ_MISM_BIT] = 1'b1;
    end
    irq_nxt = |(ists_nxt & imsk_nxt);
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      pcn_pkg::ADDR_CTRL: rd_mux[15:0] = ctrl_r & pcn_pkg::CTRL_IMPL_MASK;
      pcn_pkg::ADDR_MASK: rd_mux[PINS-1:0] = mask_r;
      pcn_pkg::ADDR_PORT: rd_mux[PINS-1:0] = pins_s;
      pcn_pkg::ADDR_EDGE: rd_mux[PINS-1:0] = edge_r;
      pcn_pkg::ADDR_MISM: rd_mux[PINS-1:0] = mism_r;
      pcn_pkg::ADDR_ISTS: rd_mux[pcn_pkg::IRQ_W-1:0] = ists_r;
      pcn_pkg::ADDR_IMSK: rd_mux[pcn_pkg::IRQ_W-1:0] = imsk_r;
      default: rd_mux = 32'h0000_0000;
    endcase
    rdata_nxt = rd_go ? rd_mux : rdata_r;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      ctrl_r <= pcn_pkg::CTRL_RESET;
      mask_r <= pcn_pkg::MASK_RESET;
      prev_r <= '0;
      last_read_r <= '0;
      edge_r <= '0;
      mism_r <= '0;
      ists_r <= '0;
      imsk_r <= '0;
      rdata_r <= 32'h0000_0000;
      irq_r <= 1'b0;
      st_r <= pcn_pkg::PCN_IDLE;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      mask_r <= mask_nxt;
      prev_r <= prev_nxt;
      last_read_r <= last_read_nxt;
      edge_r <= edge_nxt;
      mism_r <= mism_nxt;
      ists_r <= ists_nxt;
      imsk_r <= imsk_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
      st_r <= st_nxt;
    end
  end

  // Waitrequest from a flop: high except in the answer cycle
  logic wait_r, wait_nxt;
  assign wait_nxt = !(st_nxt == pcn_pkg::PCN_ACK);
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      wait_r <= 1'b1;
    end
    else
    begin
      wait_r <= wait_nxt;
    end
  end

  assign avs_waitrequest = wait_r;
  assign avs_readdata = rdata_r;
  assign irq = irq_r;
endmodule // pcn_top

// *** testbench/pcn_pins_model.sv ***
// Pin side of the port: drives the 16 pin levels.
// Assumes the bench sets the wanted levels on drive.
`timescale 1ns/1ps
module pcn_pins_model
#(
  parameter int PINS = 16
)
(
  input wire logic [PINS-1:0] drive,
  output logic [PINS-1:0] port_pins
);
  // Push-pull pins: always driven, never released
  assign port_pins = drive;
endmodule // pcn_pins_model

// *** testbench/pcn_top_props.sv ***
// Checker for pcn_top, bound to its ports.
// Assumes master releases the request at the answer edge.
`timescale 1ns/1ps
module pcn_top_props
#(
  parameter int PINS = 16
)
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [PINS-1:0] port_pins,
  input wire logic irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_ans;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  chk_bus_answer: assert property ($rose(avs_read || avs_write) |=> s_ans)
    else $error("answer not one wait state");
  chk_no_spurious: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("answer without request");
  chk_upper_zero: assert property (!avs_waitrequest && avs_read |-> avs_readdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  chk_ctrl_unimpl: assert property (!avs_waitrequest && avs_read && avs_address == 8'h00
    |-> (avs_readdata[15:0] & 16'h77ff) == 16'h0000) else $error("unused control bits set");
  chk_reset_quiet: assert property ($past(reset) |-> avs_waitrequest && !irq && avs_readdata == 32'h0)
    else $error("outputs not quiet after reset");
  chk_rdata_hold: assert property (!$stable(avs_readdata) |-> !avs_waitrequest)
    else $error("read data moved outside an answer");
endmodule // pcn_top_props
bind pcn_top pcn_top_props #(.PINS(PINS)) i_pcn_top_props(.clock(clock), .reset(reset),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .port_pins(port_pins), .irq(irq));

// *** testbench/tb.sv ***
// Self-checking bench for pcn_top over Avalon-MM.
// Assumes the slave answers within the watchdog span and pins settle in twelve cycles.
`timescale 1ns/1ps
module tb;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] pin_drive = 16'h0000;
  logic [15:0] port_pins;
  logic irq;
  logic [31:0] q;
  int n_fail = 0;
  int samples_checked = 0;
  always #2 clock = ~clock;
  pcn_pins_model i_pcn_pins_model(.drive(pin_drive), .port_pins(port_pins));
  pcn_top i_pcn_top(.clock(clock), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .port_pins(port_pins), .irq(irq));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, s, e);
    end
  endtask
  // Request held until waitrequest is seen low at a rising edge; one idle edge between requests
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic settle();
    repeat (12) @(posedge clock);
  endtask
  task automatic t_regs();
    xfer(0, 8'h00, 0); chk(q, 32'h0);
    xfer(0, 8'h04, 0); chk(q, 32'h0);
    xfer(1, 8'h00, 32'hffffffff);
    xfer(0, 8'h00, 0); chk(q, 32'h8800);
    xfer(1, 8'h04, 32'hffffffff);
    xfer(0, 8'h04, 0); chk(q, 32'hffff);
    avs_byteenable <= 4'h1;
    xfer(1, 8'h04, 32'h0);
    avs_byteenable <= 4'hf;
    xfer(0, 8'h04, 0); chk(q, 32'hff00);
    xfer(0, 8'h40, 0); chk(q, 32'h0);
    xfer(1, 8'h00, 0);
  endtask
  task automatic t_edge();
    xfer(1, 8'h04, 32'h1);
    xfer(1, 8'h18, 32'h3);
    xfer(1, 8'h00, 32'h8800);
    pin_drive <= 16'h0003;
    settle();
    xfer(0, 8'h0c, 0); chk(q, 32'h1);
    xfer(0, 8'h14, 0); chk(q, 32'h1);
    chk({31'h0, irq}, 32'h1);
    xfer(1, 8'h0c, 32'h1);
    xfer(1, 8'h14, 32'h1);
    settle();
    chk({31'h0, irq}, 32'h0);
  endtask
  task automatic t_mism();
    xfer(1, 8'h00, 32'h8000);
    xfer(0, 8'h08, 0); chk(q, 32'h3);
    xfer(0, 8'h08, 0);
    xfer(1, 8'h14, 32'h3);
    pin_drive <= 16'h0002;
    settle();
    xfer(0, 8'h10, 0); chk(q, 32'h1);
    xfer(0, 8'h14, 0); chk(q, 32'h2);
    chk({31'h0, irq}, 32'h1);
    xfer(0, 8'h08, 0);
    xfer(0, 8'h08, 0);
    xfer(0, 8'h10, 0); chk(q, 32'h0);
  endtask
  task automatic t_off();
    xfer(1, 8'h00, 32'h0800);
    xfer(1, 8'h14, 32'h3);
    pin_drive <= 16'h0001;
    settle();
    xfer(0, 8'h0c, 0); chk(q, 32'h0);
    xfer(0, 8'h14, 0); chk(q, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask
  task automatic print_verdict();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    t_regs();
    t_edge();
    t_mism();
    t_off();
    print_verdict();
  end
  // Whole run needs well under a thousand cycles
  initial
  begin
    #40000;
    n_fail++;
    print_verdict();
  end
endmodule // tb
